// [rtl/fpm_top.sv]
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "fpm_defines.svh"
module fpm_top
  import fpm_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter logic [3:0] M_RESET = `FPM_M_RESET
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [3:0] m_q;
  logic [23:0] lookup_addr;
  fpm_result_t result_q;
  fpm_result_t next_result;
  fpm_sect_raw_t raw [`FPM_NUM_SECT];
  fpm_sect_dec_t dec [`FPM_NUM_SECT];
  logic [9:0] base_pos;

  logic aw_full;
  logic w_full;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic do_write;
  logic [5:0] wr_idx;
  logic wr_ok;
  logic m_legal;

  logic [5:0] rd_idx;
  logic [31:0] rd_data;
  logic rd_ok;

  assign base_pos = (10'h001 << m_q) + 10'h001;

  // ----------------------------------------
  // section map
  // ----------------------------------------
  // bottom 8K blocks
  fpm_section #(
    .SECT_TYPE(`FPM_TYPE_8K), .COUNT_CODE(`FPM_EXP_8K),
    .START_ADDER(`FPM_S1_START), .END_ADDER(`FPM_S1_END),
    .IS_BULK(1'b0)
  ) u_sect_bot8 (.m(m_q), .raw(raw[0]), .dec(dec[0]));

  fpm_section #(
    .SECT_TYPE(`FPM_TYPE_32K), .COUNT_CODE(`FPM_EXP_32K),
    .START_ADDER(`FPM_S2_ADDER), .END_ADDER(`FPM_S2_ADDER),
    .IS_BULK(1'b0)
  ) u_sect_lo32 (.m(m_q), .raw(raw[1]), .dec(dec[1]));

  fpm_section #(
    .SECT_TYPE(`FPM_TYPE_64K), .COUNT_CODE(8'h00),
    .START_ADDER(`FPM_S3_START), .END_ADDER(`FPM_S3_END),
    .IS_BULK(1'b1)
  ) u_sect_bulk (.m(m_q), .raw(raw[2]), .dec(dec[2]));

  fpm_section #(
    .SECT_TYPE(`FPM_TYPE_32K), .COUNT_CODE(`FPM_EXP_32K),
    .START_ADDER(`FPM_S4_ADDER), .END_ADDER(`FPM_S4_ADDER),
    .IS_BULK(1'b0)
  ) u_sect_hi32 (.m(m_q), .raw(raw[3]), .dec(dec[3]));

  fpm_section #(
    .SECT_TYPE(`FPM_TYPE_8K), .COUNT_CODE(`FPM_EXP_8K),
    .START_ADDER(`FPM_S5_START), .END_ADDER(`FPM_S5_END),
    .IS_BULK(1'b0)
  ) u_sect_top8 (.m(m_q), .raw(raw[4]), .dec(dec[4]));

  // ----------------------------------------
  // address lookup
  // ----------------------------------------
  // pick the section from the 64K unit of the address, and from bit 15 in the first and last unit
  always_comb begin
    logic [8:0] n_units;
    logic [7:0] unit;
    logic [2:0] sec;
    logic [7:0] sec_idx;
    logic [9:0] step;
    n_units = 9'h001 << m_q;
    unit = lookup_addr[23:16];
    sec = 3'h2;
    sec_idx = unit - 8'h01;
    step = 10'h000;
    if (unit == 8'h00) begin
      sec = lookup_addr[15] ? 3'h1 : 3'h0;
      sec_idx = lookup_addr[15] ? 8'h00 : {6'h00, lookup_addr[14:13]};
    end else if ({1'b0, unit} == n_units - 9'h001) begin
      sec = lookup_addr[15] ? 3'h4 : 3'h3;
      sec_idx = lookup_addr[15] ? {6'h00, lookup_addr[14:13]} : 8'h00;
    end
    next_result = '0;
    next_result.in_range = ({1'b0, unit} < n_units);
    next_result.section = sec + 3'h1;
    next_result.sect_type = raw[sec].sect_type[2:0];
    next_result.is_pair = (sec == 3'h0) || (sec == 3'h4);
    step = next_result.is_pair ? {1'b0, sec_idx, 1'b0}
                               : {2'b00, sec_idx};
    next_result.write_pos = dec[sec].start_pos + step;
    next_result.read_pos = next_result.is_pair
                           ? next_result.write_pos + 10'h001
                           : next_result.write_pos;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      result_q <= '0;
    end else begin
      result_q <= next_result;
    end
  end

  // ----------------------------------------
  // write channels
  // ----------------------------------------
  assign do_write = aw_full && w_full && !s_axi_bvalid;
  assign wr_idx = aw_addr_q[7:2];

  always_ff @(posedge clk) begin
    if (reset) begin
      aw_full <= 1'b0;
      s_axi_awready <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full <= 1'b1;
      s_axi_awready <= 1'b0;
      aw_addr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_full <= 1'b0;
    end else if (!aw_full && !s_axi_awready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      w_full <= 1'b0;
      s_axi_wready <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full <= 1'b1;
      s_axi_wready <= 1'b0;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_full <= 1'b0;
    end else if (!w_full && !s_axi_wready) begin
      s_axi_wready <= 1'b1;
    end
  end

  assign m_legal = (w_data_q[3:0] >= `FPM_M_MIN) &&
                   (w_data_q[3:0] <= `FPM_M_MAX);

  always_comb begin
    wr_ok = 1'b0;
    if (wr_idx == `FPM_IDX_LOOKUP) begin
      wr_ok = 1'b1;
    end else if (wr_idx == `FPM_IDX_CONFIG) begin
      wr_ok = m_legal || !w_strb_q[0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FPM_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? `FPM_RESP_OKAY : `FPM_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // writable registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      m_q <= M_RESET;
    end else if (do_write && wr_idx == `FPM_IDX_CONFIG &&
                 w_strb_q[0] && m_legal) begin
      m_q <= w_data_q[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      lookup_addr <= 24'h00_0000;
    end else if (do_write && wr_idx == `FPM_IDX_LOOKUP) begin
      for (int b = 0; b < 3; b++) begin
        if (w_strb_q[b]) begin
          lookup_addr[b*8 +: 8] <= w_data_q[b*8 +: 8];
        end
      end
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  assign rd_idx = s_axi_araddr[7:2];

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'b1;
    case (rd_idx)
      `FPM_IDX_CONFIG: rd_data = {28'h000_0000, m_q};
      `FPM_IDX_LOOKUP: rd_data = {8'h00, lookup_addr};
      `FPM_IDX_RESULT: rd_data = result_q;
      default: begin
        rd_ok = 1'b0;
        for (int k = 0; k < `FPM_NUM_SECT; k++) begin
          if (rd_idx == 6'(`FPM_IDX_TABLE + k)) begin
            rd_data = raw[k];
            rd_ok = 1'b1;
          end
          if (rd_idx == 6'(`FPM_IDX_DECODE + k)) begin
            rd_data = dec[k];
            rd_ok = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `FPM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_ok ? `FPM_RESP_OKAY : `FPM_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid && !s_axi_arready) begin
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // bulk start at zero
  AST_BULK_START_ZERO: assert property (
    dec[2].start_pos == 10'h000 && raw[2].start_adder == 8'h00)
    else $error("bulk section does not start at bit zero");

  AST_LO32_POS: assert property (
    dec[1].start_pos == dec[1].end_pos &&
    dec[1].start_pos == base_pos - 10'h003)
    else $error("lower 32K bit position wrong");

  AST_BULK_SPAN: assert property (
    dec[2].count == 9'(dec[2].end_pos - dec[2].start_pos + 10'h001))
    else $error("bulk count differs from bit span");

  AST_TOP8_POS: assert property (
    dec[4].start_pos == base_pos + 10'h007 &&
    dec[4].end_pos == base_pos + 10'h00e)
    else $error("top 8K positions wrong");

  AST_TYPE_CODES: assert property (
    raw[0].sect_type == `FPM_TYPE_8K &&
    raw[1].sect_type == `FPM_TYPE_32K &&
    raw[2].sect_type == `FPM_TYPE_64K &&
    raw[3].sect_type == `FPM_TYPE_32K &&
    raw[4].sect_type == `FPM_TYPE_8K)
    else $error("sector type code wrong");

  AST_M_RANGE: assert property (
    $changed(m_q) |-> $past(do_write) &&
    m_q >= `FPM_M_MIN && m_q <= `FPM_M_MAX)
    else $error("density constant out of range");

  AST_LOCK_PAIR: assert property (
    result_q.is_pair |-> result_q.write_pos[0] == 1'b0 &&
    result_q.read_pos == result_q.write_pos + 10'h001)
    else $error("read and write lock pair misplaced");

  AST_FIRST_BLOCK: assert property (
    lookup_addr == 24'h00_0000 |=> result_q.section == 3'h1 &&
    result_q.write_pos == $past(base_pos) - 10'h001)
    else $error("address zero not in bottom section");

  AST_READ_ANSWER: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");

  AST_READ_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped or unstable");

endmodule

// [rtl/fpm_defines.svh]
`ifndef FPM_DEFINES_SVH
`define FPM_DEFINES_SVH

// ----------------------------------------
// register word indices (byte address = 4 x index)
// ----------------------------------------
`define FPM_IDX_CONFIG 6'h00
`define FPM_IDX_LOOKUP 6'h01
`define FPM_IDX_RESULT 6'h02
`define FPM_IDX_TABLE 6'h04
`define FPM_IDX_DECODE 6'h0c
`define FPM_NUM_SECT 5

// ----------------------------------------
// density constant
// ----------------------------------------
`define FPM_M_RESET 4'h5
`define FPM_M_MIN 4'h4
`define FPM_M_MAX 4'h8
`define FPM_M_LSB 0

// ----------------------------------------
// sector types and count exponents
// ----------------------------------------
`define FPM_TYPE_8K 8'h02
`define FPM_TYPE_32K 8'h03
`define FPM_TYPE_64K 8'h04
`define FPM_EXP_8K 8'h02
`define FPM_EXP_32K 8'h00

// ----------------------------------------
// start and end adders per section
// ----------------------------------------
`define FPM_S1_START 8'hff
`define FPM_S1_END 8'h06
`define FPM_S2_ADDER 8'hfd
`define FPM_S3_START 8'h00
`define FPM_S3_END 8'hfc
`define FPM_S4_ADDER 8'hfe
`define FPM_S5_START 8'h07
`define FPM_S5_END 8'h0e

// ----------------------------------------
// bus responses
// ----------------------------------------
`define FPM_RESP_OKAY 2'b00
`define FPM_RESP_SLVERR 2'b10

`endif

// [rtl/fpm_pkg.sv]
package fpm_pkg;

  // one section as it sits in the parameter table
  typedef struct packed {
    logic [7:0] end_adder;
    logic [7:0] start_adder;
    logic [7:0] count_code;
    logic [7:0] sect_type;
  } fpm_sect_raw_t;

  // absolute positions worked out from the adders
  typedef struct packed {
    logic [2:0] rsvd;
    logic [8:0] count;
    logic [9:0] end_pos;
    logic [9:0] start_pos;
  } fpm_sect_dec_t;

  // answer of the address lookup
  typedef struct packed {
    logic in_range;
    logic [2:0] rsvd_a;
    logic is_pair;
    logic [2:0] sect_type;
    logic rsvd_b;
    logic [2:0] section;
    logic [9:0] read_pos;
    logic [9:0] write_pos;
  } fpm_result_t;

  function automatic logic [9:0] fpm_bit_pos(
    input logic [3:0] m,
    input logic [7:0] c
  );
    logic [9:0] base;
    base = (10'h001 << m) + 10'h001;
    if (c == 8'h00) begin
      return 10'h000;
    end
    return base + {{2{c[7]}}, c};
  endfunction

endpackage

// [rtl/fpm_section.sv]
`timescale 1ns/1ps
module fpm_section
  import fpm_pkg::*;
#(
  parameter logic [7:0] SECT_TYPE = 8'h02,
  parameter logic [7:0] COUNT_CODE = 8'h00,
  parameter logic [7:0] START_ADDER = 8'h00,
  parameter logic [7:0] END_ADDER = 8'h00,
  parameter bit IS_BULK = 1'b0
) (
  input wire logic [3:0] m,
  output fpm_sect_raw_t raw,
  output fpm_sect_dec_t dec
);

  logic [8:0] bulk_count;

  assign bulk_count = (9'h001 << m) - 9'h002;

  always_comb begin
    raw.sect_type = SECT_TYPE;
    raw.start_adder = START_ADDER;
    raw.end_adder = END_ADDER;
    raw.count_code = IS_BULK ? bulk_count[7:0] : COUNT_CODE;
    dec.rsvd = 3'h0;
    dec.count = IS_BULK ? bulk_count : (9'h001 << COUNT_CODE[3:0]);
    dec.start_pos = fpm_bit_pos(m, START_ADDER);
    dec.end_pos = fpm_bit_pos(m, END_ADDER);
  end

endmodule

// [tb/fpm_host.sv]
`timescale 1ns/1ps
// ----------------------------------------
// host side: bus master and reference decoder
// ----------------------------------------
module fpm_host
  import fpm_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  output logic [ADDR_W-1:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [ADDR_W-1:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  logic [7:0] typ [5] = '{8'h02, 8'h03, 8'h04, 8'h03, 8'h02};
  logic [7:0] st [5] = '{8'hff, 8'hfd, 8'h00, 8'hfe, 8'h07};
  logic [7:0] en [5] = '{8'h06, 8'hfd, 8'hfc, 8'hfe, 8'h0e};

  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    {awvalid, wvalid, bready} <= 3'b111;
    do begin
      @(posedge clk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end while (!(bvalid && bready));
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                    output logic [1:0] r, input bit late = 1'b0);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= !late;
    do begin
      @(posedge clk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid && !rready) begin
        rready <= 1'b1;
      end
    end while (!(rvalid && rready));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // ----------------------------------------
  // reference decoder
  // ----------------------------------------
  function automatic logic [9:0] pos(input int m, input logic [7:0] c);
    if (c == 8'h00)
      return 10'h000;
    return 10'((1 << m) + 1 + int'($signed(c)));
  endfunction

  function automatic logic [31:0] exp_tab(input int m, input int s);
    logic [7:0] cnt;
    cnt = (s == 2) ? 8'((1 << m) - 2) : ((s == 1 || s == 3) ? 8'h00 : 8'h02);
    return {en[s], st[s], cnt, typ[s]};
  endfunction

  function automatic logic [31:0] exp_dec(input int m, input int s);
    int cnt;
    cnt = (s == 2) ? (1 << m) - 2 : ((s == 1 || s == 3) ? 1 : 4);
    return {3'b000, 9'(cnt), pos(m, en[s]), pos(m, st[s])};
  endfunction

  function automatic logic [31:0] exp_res(input int m, input int a);
    int sz;
    int s;
    int k;
    logic pr;
    logic [9:0] w;
    sz = 1 << (m + 16);
    pr = 1'b0;
    k = 0;
    if (a < 32'h8000) begin
      s = 0;
      k = a / 32'h2000;
      pr = 1'b1;
    end else if (a < 32'h10000) begin
      s = 1;
    end else if (a < sz - 32'h10000) begin
      s = 2;
      k = (a - 32'h10000) / 32'h10000;
    end else if (a < sz - 32'h8000) begin
      s = 3;
    end else begin
      s = 4;
      k = (a - sz + 32'h8000) / 32'h2000;
      pr = 1'b1;
    end
    w = pos(m, st[s]) + 10'(pr ? 2 * k : k);
    return {a < sz, 3'b000, pr, 3'(typ[s]), 1'b0, 3'(s + 1), w + 10'(pr), w};
  endfunction
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
`include "fpm_defines.svh"
module tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r, r2;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  int err_count = 0;
  int checks = 0;
  int sz;
  int adr [8];

  fpm_top #(.ADDR_W(8)) dut (.clk(clk), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  fpm_host #(.ADDR_W(8)) host (.clk(clk), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      err_count++;
    end
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    host.rd(8'h00, d, r, 1'b1);
    chk("config reset", 32'h5, d);
    chk("config rresp", 32'(`FPM_RESP_OKAY), 32'(r));
    for (int m = 4; m <= 8; m++) begin
      host.wr(8'h00, 32'(m), 4'hf, r);
      chk("config resp", 32'(`FPM_RESP_OKAY), 32'(r));
      for (int s = 0; s < 5; s++) begin
        host.rd({`FPM_IDX_TABLE + 6'(s), 2'b00}, d, r);
        chk("table", host.exp_tab(m, s), d);
        host.rd({`FPM_IDX_DECODE + 6'(s), 2'b00}, d, r);
        chk("decode", host.exp_dec(m, s), d);
      end
      sz = 1 << (m + 16);
      adr = '{0, 32'h6000, 32'h8000, 32'h10000, sz - 32'h10001,
              sz - 32'h10000, sz - 32'h6000, sz - 1};
      for (int i = 0; i < 8; i++) begin
        host.wr(8'h04, 32'(adr[i]), 4'hf, r);
        host.rd(8'h08, d, r);
        chk("lookup", host.exp_res(m, adr[i]), d);
      end
      if (m < 8) begin
        fork
          host.wr(8'h04, 32'(sz), 4'hf, r);
          host.rd(8'h00, d, r2);
        join
        chk("config during write", 32'(m), d);
        host.rd(8'h08, d, r);
        chk("out of range", 32'h0, {31'h0, d[31]});
      end
    end
    host.wr(8'h00, 32'h3, 4'hf, r);
    chk("m low resp", 32'(`FPM_RESP_SLVERR), 32'(r));
    host.wr(8'h00, 32'h9, 4'hf, r);
    chk("m high resp", 32'(`FPM_RESP_SLVERR), 32'(r));
    host.wr(8'h00, 32'h3, 4'he, r);
    host.rd(8'h00, d, r);
    chk("m kept", 32'h8, d);
    host.wr(8'h08, 32'h0, 4'hf, r);
    chk("ro write resp", 32'(`FPM_RESP_SLVERR), 32'(r));
    host.wr(8'h50, 32'h1, 4'hf, r);
    chk("unmapped write", 32'(`FPM_RESP_SLVERR), 32'(r));
    host.rd(8'h50, d, r);
    chk("unmapped rresp", 32'(`FPM_RESP_SLVERR), 32'(r));
    chk("unmapped rdata", 32'h0, d);
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    summarize();
  end
endmodule
